// ===== rtl/fpl_cfg.svh
// Purpose: constants of the fp load decoder
// Assumes: included by every design file that needs a number
// Notes:   word offsets on the register bus (address bits 7:2), 32-bit words
`ifndef FPL_CFG_SVH
`define FPL_CFG_SVH

// instruction format
`define FPL_OP_MEM        2'h3
`define FPL_OP3_SINGLE    6'h20
`define FPL_OP3_DOUBLE    6'h23
`define FPL_OP3_QUAD      6'h22
`define FPL_OP3_SINGLE_A  6'h30
`define FPL_OP3_DOUBLE_A  6'h33
`define FPL_OP3_QUAD_A    6'h32
`define FPL_BIT_IMM       13
`define FPL_BIT_RD1       26

// register word offsets, compared with bus address bits 7:2
`define FPL_ADR_CTRL      6'h00
`define FPL_ADR_ASI       6'h01
`define FPL_ADR_STATUS    6'h02
`define FPL_ADR_IRQ_STAT  6'h03
`define FPL_ADR_IRQ_CLR   6'h04
`define FPL_ADR_IRQ_EN    6'h05

// control register fields
`define FPL_CTRL_FEF      0
`define FPL_CTRL_PEF      1
`define FPL_CTRL_PRIV     2
`define FPL_CTRL_PRESENT  3
`define FPL_CTRL_QUAD_HW  4
`define FPL_CTRL_W        5
`define FPL_CTRL_RST      5'h0a

// interrupt status fields
`define FPL_IRQ_EXC       0
`define FPL_IRQ_DONE      1
`define FPL_IRQ_W         2

`define FPL_ASI_RST       8'h00
`define FPL_FTT_BAD_REG   3'h1

`endif

// ===== rtl/fpl_pkg.sv
// Purpose: types shared by the fp load decoder
// Assumes: nothing
// Notes:   numbers live in fpl_cfg.svh
package fpl_pkg;
  typedef enum logic [1:0] {
    FPL_SZ_SINGLE, FPL_SZ_DOUBLE, FPL_SZ_QUAD, FPL_SZ_NONE
  } fpl_size_e;

  typedef enum logic [2:0] {
    FPL_EXC_NONE, FPL_EXC_ILLEGAL, FPL_EXC_FLOAT_DISABLED_EXCEPTION,
    FPL_EXC_PRIV_ACTION, FPL_EXC_OTHER_FLOAT, FPL_EXC_MISALIGN,
    FPL_EXC_DBL_MISALIGN, FPL_EXC_QUAD_MISALIGN
  } fpl_exc_e;

  typedef enum logic [2:0] {
    FPL_ST_IDLE, FPL_ST_CHECK, FPL_ST_REQ, FPL_ST_RSP, FPL_ST_WB
  } fpl_state_e;

  typedef logic [63:0] fpl_addr_t;
endpackage : fpl_pkg

// ===== rtl/fpl_dec_if.sv
// Purpose: decode fields between the core and its helpers
// Assumes: one instruction held at a time
// Notes:   ctrl bits come from the control register
`timescale 1ns/1ps
interface fpl_dec_if;
  import fpl_pkg::*;
  logic [31:0] instr;
  fpl_addr_t   rs1;
  fpl_addr_t   rs2;
  logic [7:0]  asi_reg;
  logic [7:0]  asi_implicit;
  fpl_addr_t   ea;
  logic [7:0]  asi;
  logic        alt;
  logic        is_load;
  fpl_size_e   size;
  logic        fef;
  logic        pef;
  logic        priv;
  logic        present;
  logic        quad_hw;
  fpl_exc_e    exc;

  modport agen (input instr, rs1, rs2, asi_reg, asi_implicit,
                output ea, asi, alt, is_load, size);
  modport chk  (input instr, ea, asi, alt, is_load, size, fef, pef,
                priv, present, quad_hw, output exc);
  modport core (output instr, rs1, rs2, asi_reg, asi_implicit, fef,
                pef, priv, present, quad_hw,
                input ea, asi, alt, is_load, size, exc);
endinterface : fpl_dec_if

// ===== rtl/fpl_addr_gen.sv
// Purpose: opcode decode, effective address and space select
// Assumes: fields held stable by the core
// Notes:   pure combinational
`timescale 1ns/1ps
`include "fpl_cfg.svh"
module fpl_addr_gen (
  fpl_dec_if.agen dif
);
  import fpl_pkg::*;
  wire [5:0]  op3    = dif.instr[24:19];
  wire        is_mem = dif.instr[31:30] == `FPL_OP_MEM;
  wire        imm    = dif.instr[`FPL_BIT_IMM];
  wire [63:0] simm   = {{51{dif.instr[12]}}, dif.instr[12:0]};
  wire        op_s   = op3 == `FPL_OP3_SINGLE;
  wire        op_d   = op3 == `FPL_OP3_DOUBLE;
  wire        op_q   = op3 == `FPL_OP3_QUAD;
  wire        op_sa  = op3 == `FPL_OP3_SINGLE_A;
  wire        op_da  = op3 == `FPL_OP3_DOUBLE_A;
  wire        op_qa  = op3 == `FPL_OP3_QUAD_A;

  assign dif.is_load = is_mem & (op_s | op_d | op_q | op_sa | op_da | op_qa);
  assign dif.alt     = op_sa | op_da | op_qa;
  assign dif.size    = (op_s | op_sa) ? FPL_SZ_SINGLE :
                       (op_d | op_da) ? FPL_SZ_DOUBLE :
                       (op_q | op_qa) ? FPL_SZ_QUAD : FPL_SZ_NONE;
  assign dif.ea  = dif.rs1 + (imm ? simm : dif.rs2);
  assign dif.asi = !dif.alt ? dif.asi_implicit :
                   imm      ? dif.asi_reg : dif.instr[12:5];
endmodule : fpl_addr_gen

// ===== rtl/fpl_exc_check.sv
// Purpose: exception checks for one fp load, one winner
// Assumes: decode and address from fpl_addr_gen
// Notes:   encoding, then enable, privilege, register, alignment
`timescale 1ns/1ps
`include "fpl_cfg.svh"
module fpl_exc_check (
  fpl_dec_if.chk dif
);
  import fpl_pkg::*;
  wire quad     = dif.size == FPL_SZ_QUAD;
  wire dbl      = dif.size == FPL_SZ_DOUBLE;
  wire bad_bits = !dif.alt && !dif.instr[`FPL_BIT_IMM] &&
                  dif.instr[12:5] != 8'h00;
  wire no_quad  = quad && !dif.quad_hw;
  wire fp_off   = !dif.fef || !dif.pef || !dif.present;
  wire priv_bad = dif.alt && !dif.priv && !dif.asi[7];
  wire bad_reg  = quad && dif.instr[`FPL_BIT_RD1];
  wire mis_w    = dif.ea[1:0] != 2'h0;
  wire mis_d    = dbl && dif.ea[2];
  wire mis_q    = quad && dif.ea[3:2] != 2'h0;

  assign dif.exc = !dif.is_load         ? FPL_EXC_NONE :
                   (bad_bits | no_quad) ? FPL_EXC_ILLEGAL :
                   fp_off               ? FPL_EXC_FLOAT_DISABLED_EXCEPTION :
                   priv_bad             ? FPL_EXC_PRIV_ACTION :
                   bad_reg              ? FPL_EXC_OTHER_FLOAT :
                   mis_w                ? FPL_EXC_MISALIGN :
                   mis_d                ? FPL_EXC_DBL_MISALIGN :
                   mis_q                ? FPL_EXC_QUAD_MISALIGN :
                                          FPL_EXC_NONE;
endmodule : fpl_exc_check

// ===== rtl/fpl_load_decode_check.sv
// Purpose: fp register load decoder, checker and word fetcher
// Assumes: issue, memory and register file on clk_i
// Notes:   Wishbone classic slave for control and interrupts
`timescale 1ns/1ps
`include "fpl_cfg.svh"
module fpl_load_decode_check #(
  parameter logic [2:0] BAD_REG_FTT = `FPL_FTT_BAD_REG
) (
  // clock and reset
  input  wire  logic                clk_i,
  input  wire  logic                rst_i,
  // register bus
  input  wire  logic                wb_cyc_i,
  input  wire  logic                wb_stb_i,
  input  wire  logic                wb_we_i,
  input  wire  logic [7:0]          wb_adr_i,
  input  wire  logic [3:0]          wb_sel_i,
  input  wire  logic [31:0]         wb_dat_i,
  output logic       [31:0]         wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      irq_o,
  // issue stage
  input  wire  logic                iss_valid_i,
  output logic                      iss_ready_o,
  input  wire  logic [31:0]         iss_instr_i,
  input  wire  fpl_pkg::fpl_addr_t  iss_rs1_i,
  input  wire  fpl_pkg::fpl_addr_t  iss_rs2_i,
  input  wire  logic [7:0]          implicit_asi_i,
  // memory path
  output logic                      mem_req_valid_o,
  input  wire  logic                mem_req_ready_i,
  output fpl_pkg::fpl_addr_t        mem_addr_o,
  output logic       [7:0]          mem_asi_o,
  input  wire  logic                mem_rsp_valid_i,
  input  wire  logic [31:0]         mem_rsp_data_i,
  // fp register file
  output logic                      fpr_we_o,
  output logic       [5:0]          fpr_idx_o,
  output fpl_pkg::fpl_size_e        fpr_size_o,
  output logic       [127:0]        fpr_data_o,
  // exception report
  output logic                      exc_valid_o,
  output fpl_pkg::fpl_exc_e         exc_code_o,
  output logic       [2:0]          exc_ftt_o
);
  import fpl_pkg::*;

  fpl_dec_if dif ();

  fpl_state_e              state_r;
  logic [31:0]             instr_r;
  fpl_addr_t               rs1_r;
  fpl_addr_t               rs2_r;
  logic [1:0]              cnt_r;
  logic [127:0]            data_r;
  logic [`FPL_CTRL_W-1:0]  ctrl_r;
  logic [7:0]              asi_r;
  logic [`FPL_IRQ_W-1:0]   irq_stat_r;
  logic [`FPL_IRQ_W-1:0]   irq_stat_nxt;
  logic [`FPL_IRQ_W-1:0]   irq_en_r;
  fpl_exc_e                last_exc_r;
  logic                    ack_r;

  //////////////////////////////////////////////////////////////////////
  // decode helpers
  assign dif.instr        = instr_r;
  assign dif.rs1          = rs1_r;
  assign dif.rs2          = rs2_r;
  assign dif.asi_reg      = asi_r;
  assign dif.asi_implicit = implicit_asi_i;
  assign dif.fef          = ctrl_r[`FPL_CTRL_FEF];
  assign dif.pef          = ctrl_r[`FPL_CTRL_PEF];
  assign dif.priv         = ctrl_r[`FPL_CTRL_PRIV];
  assign dif.present      = ctrl_r[`FPL_CTRL_PRESENT];
  assign dif.quad_hw      = ctrl_r[`FPL_CTRL_QUAD_HW];

  fpl_addr_gen  u_agen (.dif(dif));
  fpl_exc_check u_chk  (.dif(dif));

  //////////////////////////////////////////////////////////////////////
  // sequencer
  wire       take     = iss_valid_i && iss_ready_o;
  wire       in_check = state_r == FPL_ST_CHECK;
  wire       faulted  = in_check && dif.is_load && dif.exc != FPL_EXC_NONE;
  wire       go_fetch = in_check && dif.is_load && dif.exc == FPL_EXC_NONE;
  wire       req_done = state_r == FPL_ST_REQ && mem_req_ready_i;
  wire       rsp_done = state_r == FPL_ST_RSP && mem_rsp_valid_i;
  wire [1:0] last_w   = dif.size == FPL_SZ_QUAD   ? 2'h3 :
                        dif.size == FPL_SZ_DOUBLE ? 2'h1 : 2'h0;
  wire       last_rsp = rsp_done && cnt_r == last_w;
  wire [5:0] dest_idx = dif.size == FPL_SZ_SINGLE ? {1'b0, instr_r[29:25]}
                        : {instr_r[25], instr_r[29:26], 1'b0};

  assign iss_ready_o     = state_r == FPL_ST_IDLE;
  assign mem_req_valid_o = state_r == FPL_ST_REQ;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= FPL_ST_IDLE;
    end else begin
      case (state_r)
        FPL_ST_IDLE:  if (take) state_r <= FPL_ST_CHECK;
        FPL_ST_CHECK: state_r <= go_fetch ? FPL_ST_REQ : FPL_ST_IDLE;
        FPL_ST_REQ:   if (req_done) state_r <= FPL_ST_RSP;
        FPL_ST_RSP:   if (rsp_done) begin
          state_r <= last_rsp ? FPL_ST_WB : FPL_ST_REQ;
        end
        FPL_ST_WB:    state_r <= FPL_ST_IDLE;
        default:      state_r <= FPL_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_r <= 32'h0;
      rs1_r   <= 64'h0;
      rs2_r   <= 64'h0;
    end else if (take) begin
      instr_r <= iss_instr_i;
      rs1_r   <= iss_rs1_i;
      rs2_r   <= iss_rs2_i;
    end
  end

  // one word per request, lowest address ends up most significant
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r      <= 2'h0;
      data_r     <= 128'h0;
      mem_addr_o <= 64'h0;
      mem_asi_o  <= 8'h00;
    end else if (go_fetch) begin
      cnt_r      <= 2'h0;
      mem_addr_o <= dif.ea;
      mem_asi_o  <= dif.asi;
    end else if (rsp_done) begin
      cnt_r      <= cnt_r + 2'h1;
      data_r     <= {data_r[95:0], mem_rsp_data_i};
      mem_addr_o <= mem_addr_o + 64'h4;
    end
  end

  // register file written only after every word arrived
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fpr_we_o   <= 1'b0;
      fpr_idx_o  <= 6'h00;
      fpr_size_o <= FPL_SZ_NONE;
      fpr_data_o <= 128'h0;
    end else begin
      fpr_we_o <= state_r == FPL_ST_WB;
      if (state_r == FPL_ST_WB) begin
        fpr_idx_o  <= dest_idx;
        fpr_size_o <= dif.size;
        fpr_data_o <= dif.size == FPL_SZ_SINGLE ? {96'h0, data_r[31:0]} :
                      dif.size == FPL_SZ_DOUBLE ? {64'h0, data_r[63:0]} :
                      data_r;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exc_valid_o <= 1'b0;
      exc_code_o  <= FPL_EXC_NONE;
      exc_ftt_o   <= 3'h0;
      last_exc_r  <= FPL_EXC_NONE;
    end else begin
      exc_valid_o <= faulted;
      if (faulted) begin
        exc_code_o <= dif.exc;
        exc_ftt_o  <= dif.exc == FPL_EXC_OTHER_FLOAT ? BAD_REG_FTT
                      : 3'h0;
        last_exc_r <= dif.exc;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register bus
  wire       acc    = wb_cyc_i && wb_stb_i;
  wire       wr     = acc && wb_we_i && ack_r && wb_sel_i[0];
  wire [5:0] widx   = wb_adr_i[7:2];
  wire       wr_ctl = wr && widx == `FPL_ADR_CTRL;
  wire       wr_asi = wr && widx == `FPL_ADR_ASI;
  wire       wr_clr = wr && widx == `FPL_ADR_IRQ_CLR;
  wire       wr_en  = wr && widx == `FPL_ADR_IRQ_EN;
  wire [`FPL_IRQ_W-1:0] irq_set = {state_r == FPL_ST_WB, faulted};
  wire [31:0] rd_mux =
    widx == `FPL_ADR_CTRL     ? {27'h0, ctrl_r} :
    widx == `FPL_ADR_ASI      ? {24'h0, asi_r} :
    widx == `FPL_ADR_STATUS   ? {21'h0, state_r, 5'h0, last_exc_r} :
    widx == `FPL_ADR_IRQ_STAT ? {30'h0, irq_stat_r} :
    widx == `FPL_ADR_IRQ_EN   ? {30'h0, irq_en_r} : 32'h0;

  assign wb_ack_o = ack_r;
  // a new event wins over a clear in the same cycle
  assign irq_stat_nxt = (irq_stat_r &
                         ~(wr_clr ? wb_dat_i[`FPL_IRQ_W-1:0] : 2'h0)) |
                        irq_set;
  assign irq_o = |(irq_stat_r & irq_en_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_r <= acc && !ack_r;
      if (acc && !ack_r) wb_dat_o <= rd_mux;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r     <= `FPL_CTRL_RST;
      asi_r      <= `FPL_ASI_RST;
      irq_en_r   <= 2'h0;
      irq_stat_r <= 2'h0;
    end else begin
      if (wr_ctl) ctrl_r <= wb_dat_i[`FPL_CTRL_W-1:0];
      if (wr_asi) asi_r <= wb_dat_i[7:0];
      if (wr_en) irq_en_r <= wb_dat_i[`FPL_IRQ_W-1:0];
      irq_stat_r <= irq_stat_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [2:0] words_seen_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || go_fetch) words_seen_r <= 3'h0;
    else if (rsp_done) words_seen_r <= words_seen_r + 3'h1;
  end

  sequence s_word_asked;
    mem_req_valid_o && mem_req_ready_i;
  endsequence
  sequence s_word_back;
    state_r == FPL_ST_RSP ##[0:1000] mem_rsp_valid_i;
  endsequence

  no_write_trap_a: assert property (faulted |=> exc_valid_o &&
    !fpr_we_o ##1 !fpr_we_o)
    else $error("register written after a trap");
  ea_first_word_a: assert property (go_fetch |=> mem_addr_o ==
    $past(rs1_r) + ($past(instr_r[13]) ?
    {{51{$past(instr_r[12])}}, $past(instr_r[12:0])} : $past(rs2_r)))
    else $error("first word address wrong");
  illegal_bits_a: assert property (in_check && dif.is_load &&
    !dif.alt && !instr_r[13] && instr_r[12:5] != 8'h00
    |=> exc_valid_o && exc_code_o == FPL_EXC_ILLEGAL)
    else $error("nonzero bits 12:5 not illegal");
  float_disabled_exception_a: assert property (in_check && dif.is_load &&
    dif.exc != FPL_EXC_ILLEGAL && !ctrl_r[`FPL_CTRL_PEF]
    |=> exc_code_o == FPL_EXC_FLOAT_DISABLED_EXCEPTION)
    else $error("disabled unit not reported");
  word_misalign_a: assert property (go_fetch &&
    dif.size == FPL_SZ_SINGLE |-> dif.ea[1:0] == 2'h0)
    else $error("misaligned single fetched");
  dbl_misalign_a: assert property (faulted &&
    dif.size == FPL_SZ_DOUBLE && dif.ea[2:0] == 3'h4 &&
    dif.exc > FPL_EXC_OTHER_FLOAT |=> exc_code_o == FPL_EXC_DBL_MISALIGN)
    else $error("double misalign wrong code");
  bad_quad_reg_a: assert property (exc_valid_o &&
    exc_code_o == FPL_EXC_OTHER_FLOAT |-> exc_ftt_o == BAD_REG_FTT &&
    $past(instr_r[26]))
    else $error("bad register report wrong");
  priv_action_a: assert property (faulted &&
    dif.exc == FPL_EXC_PRIV_ACTION |-> dif.alt && !dif.asi[7] &&
    !ctrl_r[`FPL_CTRL_PRIV])
    else $error("privileged action without cause");
  word_count_a: assert property (fpr_we_o |->
    words_seen_r == {1'b0, last_w} + 3'h1)
    else $error("wrong number of words written");
  word_fetch_a: assert property (s_word_asked |=> s_word_back)
    else $error("word answer missing");
endmodule : fpl_load_decode_check

// ===== tb/fpl_mem_model.sv
// Purpose: memory path partner, one word answer per request
// Assumes: request held until ready, one word outstanding
// Notes:   dly_i sets both ready and answer latency
`timescale 1ns/1ps
module fpl_mem_model (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // request side
  input  wire logic               req_valid_i,
  input  wire fpl_pkg::fpl_addr_t addr_i,
  input  wire logic [3:0]         dly_i,
  output logic                    req_ready_o,
  // answer side
  output logic                    rsp_valid_o,
  output logic [31:0]             rsp_data_o
);
  import fpl_pkg::*;
  logic [3:0]  cnt_r;
  logic        pend_r;
  logic [31:0] word_r;
  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    rsp_valid_o <= 1'b0;
    // data line keeps moving when no answer stands
    rsp_data_o  <= ~rsp_data_o;
    if (rst_i) begin
      cnt_r       <= 4'h0;
      pend_r      <= 1'b0;
      req_ready_o <= 1'b0;
      rsp_data_o  <= 32'h0;
    end else if (pend_r) begin
      if (cnt_r >= dly_i) begin
        rsp_valid_o <= 1'b1;
        rsp_data_o  <= word_r;
        pend_r      <= 1'b0;
        cnt_r       <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end else if (req_valid_i && req_ready_o) begin
      req_ready_o <= 1'b0;
      pend_r      <= 1'b1;
      word_r      <= addr_i[31:0] ^ 32'h5a5a0000;
    end else if (req_valid_i) begin
      if (cnt_r >= dly_i) begin
        req_ready_o <= 1'b1;
        cnt_r       <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule : fpl_mem_model

// ===== tb/test_fpl_load_decode_check.sv
// Purpose: self-checking bench for the fp load decoder
// Assumes: memory partner fpl_mem_model, registers over Wishbone
// Notes:   drive on rising edge, bus answer taken on the ack edge
`timescale 1ns/1ps
`include "fpl_cfg.svh"
module test_fpl_load_decode_check;
  import fpl_pkg::*;
  logic         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]   wb_adr_i, implicit_asi_i, mem_asi_o;
  logic [3:0]   wb_sel_i, mem_dly;
  logic [31:0]  wb_dat_i, wb_dat_o, iss_instr_i, mem_rsp_data_i, q;
  logic         irq_o, iss_valid_i, iss_ready_o, mem_req_valid_o;
  logic         mem_req_ready_i, mem_rsp_valid_i, fpr_we_o, exc_valid_o;
  fpl_addr_t    iss_rs1_i, iss_rs2_i, mem_addr_o;
  logic [5:0]   fpr_idx_o;
  fpl_size_e    fpr_size_o;
  logic [127:0] fpr_data_o;
  fpl_exc_e     exc_code_o;
  logic [2:0]   exc_ftt_o;
  logic [31:0]  dis [3] = '{32'h1e, 32'h1d, 32'h17};
  int           fails, check_count;
  //////////////////////////////////////////////////////////////////////
  fpl_load_decode_check uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .iss_valid_i(iss_valid_i),
    .iss_ready_o(iss_ready_o), .iss_instr_i(iss_instr_i),
    .iss_rs1_i(iss_rs1_i), .iss_rs2_i(iss_rs2_i),
    .implicit_asi_i(implicit_asi_i), .mem_req_valid_o(mem_req_valid_o),
    .mem_req_ready_i(mem_req_ready_i), .mem_addr_o(mem_addr_o),
    .mem_asi_o(mem_asi_o), .mem_rsp_valid_i(mem_rsp_valid_i),
    .mem_rsp_data_i(mem_rsp_data_i), .fpr_we_o(fpr_we_o),
    .fpr_idx_o(fpr_idx_o), .fpr_size_o(fpr_size_o),
    .fpr_data_o(fpr_data_o), .exc_valid_o(exc_valid_o),
    .exc_code_o(exc_code_o), .exc_ftt_o(exc_ftt_o));
  fpl_mem_model mem (
    .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(mem_req_valid_o),
    .addr_i(mem_addr_o), .dly_i(mem_dly), .req_ready_o(mem_req_ready_i),
    .rsp_valid_o(mem_rsp_valid_i), .rsp_data_o(mem_rsp_data_i));
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // request stands until the edge that samples ack high
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc
  task automatic irqc(input logic e);
    @(negedge clk_i);
    chk(irq_o, e);
  endtask : irqc
  function automatic logic [31:0] mk(input logic [5:0] op,
                                     input logic [4:0] rd,
                                     input logic [13:0] lo);
    return {2'b11, rd, op, 5'h00, lo};
  endfunction : mk
  function automatic logic [127:0] ed(input fpl_addr_t ea,
                                      input fpl_size_e sz);
    logic [127:0] r;
    fpl_addr_t    w;
    int           n;
    r = '0;
    n = sz == FPL_SZ_QUAD ? 4 : sz == FPL_SZ_DOUBLE ? 2 : 1;
    for (int k = 0; k < n; k++) begin
      w = ea + 64'(4 * k);
      r = {r[95:0], w[31:0] ^ 32'h5a5a0000};
    end
    return r;
  endfunction : ed
  task automatic ld(input logic [31:0] ins, input fpl_addr_t a, b,
                    input logic [7:0] xa, input fpl_exc_e ec,
                    input logic [5:0] ix, input fpl_size_e sz);
    fpl_addr_t ea;
    int        n;
    ea = ins[13] ? a + {{51{ins[12]}}, ins[12:0]} : a + b;
    do @(negedge clk_i); while (iss_ready_o !== 1'b1);
    @(posedge clk_i);
    iss_valid_i <= 1'b1;
    iss_instr_i <= ins;
    iss_rs1_i   <= a;
    iss_rs2_i   <= b;
    @(posedge clk_i);
    iss_valid_i <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      if (mem_req_valid_o === 1'b1) chk(mem_asi_o, xa);
    end while (fpr_we_o !== 1'b1 && exc_valid_o !== 1'b1 && n < 80);
    chk(exc_valid_o, ec != FPL_EXC_NONE);
    chk(fpr_we_o, ec == FPL_EXC_NONE && sz != FPL_SZ_NONE);
    if (ec != FPL_EXC_NONE) begin
      chk(exc_code_o, ec);
      chk(exc_ftt_o, ec == FPL_EXC_OTHER_FLOAT ? `FPL_FTT_BAD_REG
          : 3'h0);
    end else if (sz != FPL_SZ_NONE) begin
      chk(fpr_idx_o, ix);
      chk(fpr_size_o, sz);
      chk(fpr_data_o, ed(ea, sz));
    end
    $display("test load %h ended", ins);
  endtask : ld
  //////////////////////////////////////////////////////////////////////
  initial begin
    #(20 * 20000);
    fails++;
    end_sim();
  end
  initial begin
    fails = 0;
    check_count = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, iss_valid_i} = 4'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hf;
    iss_instr_i = 32'h0;
    iss_rs1_i = '0;
    iss_rs2_i = '0;
    implicit_asi_i = 8'h80;
    mem_dly = 4'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(iss_ready_o, 1'b1);
    chk(fpr_size_o, FPL_SZ_NONE);
    rdc(8'h00, 32'h0a);
    rdc(8'h04, 32'h0);
    rdc(8'h0c, 32'h0);
    rdc(8'h14, 32'h0);
    rdc(8'h18, 32'h0);
    $display("test reset ended");
    wb(1'b1, 8'h00, 32'h1f);
    wb(1'b1, 8'h04, 32'h82);
    wb(1'b1, 8'h14, 32'h03);
    ld(mk(6'h20, 5'h05, 14'h3ffc), 64'h1000, 64'h0, 8'h80,
       FPL_EXC_NONE, 6'h05, FPL_SZ_SINGLE);
    mem_dly = 4'h3;
    ld(mk(6'h20, 5'h1f, 14'h0000), 64'h2000, 64'h24, 8'h80,
       FPL_EXC_NONE, 6'h1f, FPL_SZ_SINGLE);
    ld(mk(6'h23, 5'h03, 14'h2008), 64'h3000, 64'h0, 8'h80,
       FPL_EXC_NONE, 6'h22, FPL_SZ_DOUBLE);
    mem_dly = 4'h0;
    ld(mk(6'h22, 5'h09, 14'h0000), 64'h4000, 64'h10, 8'h80,
       FPL_EXC_NONE, 6'h28, FPL_SZ_QUAD);
    ld(mk(6'h30, 5'h02, 14'h1020), 64'h5000, 64'h4, 8'h81,
       FPL_EXC_NONE, 6'h02, FPL_SZ_SINGLE);
    ld(mk(6'h33, 5'h04, 14'h2000), 64'h6008, 64'h0, 8'h82,
       FPL_EXC_NONE, 6'h04, FPL_SZ_DOUBLE);
    ld(mk(6'h32, 5'h00, 14'h1060), 64'h7000, 64'h0, 8'h83,
       FPL_EXC_NONE, 6'h00, FPL_SZ_QUAD);
    ld(mk(6'h20, 5'h01, 14'h0020), 64'h1001, 64'h0, 8'h80,
       FPL_EXC_ILLEGAL, 6'h0, FPL_SZ_NONE);
    ld(mk(6'h20, 5'h01, 14'h2002), 64'h1000, 64'h0, 8'h80,
       FPL_EXC_MISALIGN, 6'h0, FPL_SZ_NONE);
    ld(mk(6'h23, 5'h02, 14'h2004), 64'h1000, 64'h0, 8'h80,
       FPL_EXC_DBL_MISALIGN, 6'h0, FPL_SZ_NONE);
    ld(mk(6'h23, 5'h02, 14'h2002), 64'h1000, 64'h0, 8'h80,
       FPL_EXC_MISALIGN, 6'h0, FPL_SZ_NONE);
    ld(mk(6'h22, 5'h00, 14'h2008), 64'h1000, 64'h0, 8'h80,
       FPL_EXC_QUAD_MISALIGN, 6'h0, FPL_SZ_NONE);
    ld(mk(6'h22, 5'h02, 14'h2004), 64'h1000, 64'h0, 8'h80,
       FPL_EXC_OTHER_FLOAT, 6'h0, FPL_SZ_NONE);
    rdc(8'h08, 32'h4);
    rdc(8'h0c, 32'h3);
    irqc(1'b1);
    wb(1'b1, 8'h10, 32'h1);
    rdc(8'h0c, 32'h2);
    wb(1'b1, 8'h14, 32'h1);
    irqc(1'b0);
    wb(1'b1, 8'h10, 32'h2);
    rdc(8'h0c, 32'h0);
    wb(1'b1, 8'h14, 32'h3);
    $display("test interrupt ended");
    wb(1'b1, 8'h00, 32'h1b);
    ld(mk(6'h30, 5'h01, 14'h0fe0), 64'h100, 64'h0, 8'h7f,
       FPL_EXC_PRIV_ACTION, 6'h0, FPL_SZ_NONE);
    ld(mk(6'h30, 5'h01, 14'h1000), 64'h100, 64'h8, 8'h80,
       FPL_EXC_NONE, 6'h01, FPL_SZ_SINGLE);
    foreach (dis[k]) begin
      wb(1'b1, 8'h00, dis[k]);
      ld(mk(6'h23, 5'h00, 14'h2004), 64'h1000, 64'h0, 8'h80,
         FPL_EXC_FLOAT_DISABLED_EXCEPTION, 6'h0, FPL_SZ_NONE);
    end
    wb(1'b1, 8'h00, 32'h0f);
    ld(mk(6'h22, 5'h00, 14'h2000), 64'h1000, 64'h0, 8'h80,
       FPL_EXC_ILLEGAL, 6'h0, FPL_SZ_NONE);
    wb(1'b1, 8'h00, 32'h1f);
    ld(mk(6'h00, 5'h00, 14'h2000), 64'h1000, 64'h0, 8'h80,
       FPL_EXC_NONE, 6'h0, FPL_SZ_NONE);
    end_sim();
  end
endmodule : test_fpl_load_decode_check
